// File: design/wss_flag_bank.sv
// Sticky event flags with clear access; a set in the clear cycle wins
module wss_flag_bank
    import wss_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic soft_rst,
    // Events and clear
    input wire logic [W-1:0] set_vec,
    input wire logic clr,
    // Flag state
    output logic [W-1:0] flags
);

    typedef struct packed {
        logic [W-1:0] flags;
    } wss_bank_t;

    wss_bank_t st_r; // Registered state
    wss_bank_t st_nxt; // Next state

    // Next flag value: soft reset zeroes, else clear then set
    always_comb begin
        st_nxt = st_r;
        if (soft_rst) begin
            st_nxt.flags = '0; // R4
        end else begin
            if (clr) begin
                st_nxt.flags = '0; // R18
            end
            st_nxt.flags = st_nxt.flags | set_vec; // R18
        end
    end

    // State register; restart has no effect so flags are kept
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0; // R4
        end else begin
            st_r <= st_nxt; // R5 R17
        end
    end

    assign flags = st_r.flags;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_set_wins_clear: assert property (!soft_rst && |set_vec |=> (flags & $past(set_vec)) == $past(set_vec)) // R18
        else $error("event lost against clear");
    chk_flag_held: assert property (!soft_rst && !clr |=> (flags & $past(flags)) == $past(flags)) // R18
        else $error("flag dropped without clear");
    chk_soft_zero: assert property (soft_rst |=> flags == '0) // R4
        else $error("soft reset left a flag set");
    cov_clear_with_set: cover property (clr && |set_vec);

endmodule

// File: design/wss_level_capture.sv
// Level capture for wake inputs and general-purpose pins
module wss_level_capture
    import wss_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wake inputs and sampling
    input wire logic [2:0] wake_in_pin,
    input wire logic [2:0] wake_cyclic,
    input wire logic sample_strobe,
    // General-purpose pins
    input wire logic [1:0] gen_pin,
    input wss_mode_t sbc_mode,
    input wss_gcfg_t gen_cfg1,
    input wss_gcfg_t gen_cfg2,
    input wire logic [1:0] gen_sel_gpio,
    // Captured levels
    output logic [2:0] wake_lvl,
    output logic [1:0] gen_lvl
);

    typedef struct packed {
        logic [2:0] wake_lvl;
        logic [1:0] gen_lvl;
    } wss_lvl_t;

    wss_lvl_t st_r; // Registered levels
    wss_lvl_t st_nxt; // Next levels
    logic gen_mode_ok; // Normal or stop mode
    logic [1:0] gen_upd; // Per-pin update permission

    // Update permission of the general pins
    always_comb begin
        gen_mode_ok = (sbc_mode == WSS_MODE_NORMAL) || (sbc_mode == WSS_MODE_STOP); // R10
        gen_upd[0] = gen_sel_gpio[0] || (gen_mode_ok && gen_cfg1 != WSS_GCFG_OFF); // R10 R13
        gen_upd[1] = gen_sel_gpio[1] || (gen_mode_ok && gen_cfg2 != WSS_GCFG_OFF); // R10 R13
    end

    // Next levels; cyclic wake inputs only move on a sample
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < 3; i++) begin
            if (!wake_cyclic[i] || sample_strobe) begin
                st_nxt.wake_lvl[i] = wake_in_pin[i]; // R11
            end
        end
        for (int j = 0; j < 2; j++) begin
            if (gen_upd[j]) begin
                st_nxt.gen_lvl[j] = gen_pin[j]; // R12
            end
        end
    end

    // Level register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wake_lvl = st_r.wake_lvl;
    assign gen_lvl = st_r.gen_lvl;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_cyclic_hold: assert property (wake_cyclic[0] && !sample_strobe |=> wake_lvl[0] == $past(wake_lvl[0])) // R11
        else $error("cyclic wake level moved between samples");
    chk_cyclic_sample: assert property (sample_strobe |=> wake_lvl == $past(wake_in_pin)) // R11
        else $error("sampled wake level not stored");
    chk_gen_hold: assert property (!gen_upd[0] |=> gen_lvl[0] == $past(gen_lvl[0])) // R10
        else $error("general level moved while not enabled");
    cov_gen_sel: cover property (gen_sel_gpio[1] && gen_cfg2 == WSS_GCFG_HIGH_SIDE);

endmodule

// File: design/wss_pkg.sv
// How it works
// [R1] Bus undervolt comparator follows transceiver mode bit
// [R2] Wake flags mark bus, timer, wake, general pins
// [R3] Fail-safe wake events set the same flags
// [R4] Power-on or soft reset zeroes all flags
// [R5] Restart keeps wake flags, reserved bits zero
// [R6] Reserved positions always read as zero
// [R7] Level bit 7 shows development-mode strap
// [R8] Level bit 6 shows interrupt pull-up strap
// [R9] Level register shows pin and wake-input levels
// [R10] General level updates in normal/stop when configured
// [R11] Cyclic wake inputs refresh on each sample
// [R12] General pins never use cyclic sampling
// [R13] Pin selected as general shows level anyway
// [R14] Four switch overload flags, switch four highest
// [R15] Four switch open-load flags, separate register
// [R16] Host treats overload flags cautiously at low supply
// [R17] Restart keeps switch flags, upper nibble zero
// [R18] Flags stay set until host clear access
package wss_pkg;

    // Register addresses on the serial control interface
    localparam logic [6:0] WSS_ADDR_WAKE_A = 7'h46;
    localparam logic [6:0] WSS_ADDR_WAKE_B = 7'h47;
    localparam logic [6:0] WSS_ADDR_LEVEL = 7'h48;
    localparam logic [6:0] WSS_ADDR_OVERLOAD = 7'h54;
    localparam logic [6:0] WSS_ADDR_OPEN_LOAD = 7'h55;

    // Field positions in wake source register a
    localparam int WSS_POS_BUS_WAKE = 5;
    localparam int WSS_POS_TIMER_WAKE = 4;
    localparam int WSS_POS_WAKE_IN_LO = 0;

    // Field positions in wake source register b
    localparam int WSS_POS_GEN_WAKE_LO = 4;

    // Field positions in the level register
    localparam int WSS_POS_DEV_STRAP = 7;
    localparam int WSS_POS_PULLUP_STRAP = 6;
    localparam int WSS_POS_GEN_LVL_LO = 4;
    localparam int WSS_POS_WAKE_LVL_LO = 0;

    // Field position of switch flags in both switch registers
    localparam int WSS_POS_SWITCH_LO = 0;

    // Reset value and value read at unmapped addresses
    localparam logic [7:0] WSS_RST_STATUS = 8'h00;
    localparam logic [7:0] WSS_RD_UNMAPPED = 8'h00;

    // Operating mode reported by the mode controller
    typedef enum logic [1:0] {
        WSS_MODE_NORMAL = 2'b00,
        WSS_MODE_STOP = 2'b01,
        WSS_MODE_SLEEP = 2'b10,
        WSS_MODE_OTHER = 2'b11
    } wss_mode_t;

    // Function configured on a general-purpose pin
    typedef enum logic [1:0] {
        WSS_GCFG_OFF = 2'b00,
        WSS_GCFG_WAKE = 2'b01,
        WSS_GCFG_LOW_SIDE = 2'b10,
        WSS_GCFG_HIGH_SIDE = 2'b11
    } wss_gcfg_t;

endpackage

// File: design/wss_status_regs.sv
// Wake and switch status register group
module wss_status_regs
    import wss_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic restart,
    // Register access from the serial control interface
    input wire logic rd_en,
    input wire logic clr_en,
    input wire logic [6:0] reg_addr,
    output logic [7:0] rd_data,
    // Bus transceiver
    input wire logic bus_xcvr_mode,
    output logic bus_supply_undervolt_en,
    // Wake events, normal and from fail-safe
    input wire logic bus_wake_evt,
    input wire logic timer_wake_evt,
    input wire logic [2:0] wake_in_evt,
    input wire logic [1:0] gen_pin_wake_evt,
    input wire logic failsafe_wake,
    // Wake input and general pin levels
    input wire logic [2:0] wake_in_pin,
    input wire logic [2:0] wake_cyclic,
    input wire logic sample_strobe,
    input wire logic [1:0] gen_pin,
    input wss_mode_t sbc_mode,
    input wss_gcfg_t gen_cfg1,
    input wss_gcfg_t gen_cfg2,
    input wire logic [1:0] gen_sel_gpio,
    // Configuration straps
    input wire logic fail_out3_test_pin,
    input wire logic int_pullup_sense,
    // High-side switch diagnostics
    input wire logic [3:0] switch_overload_evt,
    input wire logic [3:0] switch_open_load_evt
);

    // Whole state of the top: read data, comparator enable, straps and capture control
    typedef struct packed {
        logic [7:0] rd_data;
        logic bus_uv_en;
        logic dev_mode_strap;
        logic int_pullup_strap;
        logic strap_take;
    } wss_top_t;

    wss_top_t st_r; // Registered state
    wss_top_t st_nxt; // Next state

    // Flag views
    logic [4:0] wake_a_flags; // Bus, timer, wake inputs three..one
    logic [1:0] wake_b_flags; // General pins two and one
    logic [3:0] overload_flags; // Switch overload
    logic [3:0] open_load_flags; // Switch open load
    logic [2:0] wake_lvl; // Wake input levels
    logic [1:0] gen_lvl; // General pin levels

    // Set and clear strobes of the flag banks
    logic [4:0] wake_a_set;
    logic [1:0] wake_b_set;
    logic clr_wake_a;
    logic clr_wake_b;
    logic clr_overload;
    logic clr_open_load;

    // Assembled register images
    logic [7:0] img_wake_a;
    logic [7:0] img_wake_b;
    logic [7:0] img_level;
    logic [7:0] img_overload;
    logic [7:0] img_open_load;
    logic [7:0] rd_mux;

    // Wake sources; a fail-safe wake sets the same flag as a normal one
    always_comb begin
        wake_a_set = {bus_wake_evt, timer_wake_evt, wake_in_evt}; // R2 R3
        wake_b_set = gen_pin_wake_evt; // R2 R3
    end

    // Clear access decode; a clear acts only on its own register
    always_comb begin
        clr_wake_a = clr_en && (reg_addr == WSS_ADDR_WAKE_A); // R18
        clr_wake_b = clr_en && (reg_addr == WSS_ADDR_WAKE_B); // R18
        clr_overload = clr_en && (reg_addr == WSS_ADDR_OVERLOAD); // R18
        clr_open_load = clr_en && (reg_addr == WSS_ADDR_OPEN_LOAD); // R18
    end

    // Wake source register a flags
    wss_flag_bank #(
        .W(5)
    ) u_wake_a (
        .clk_sys(clk_sys),
        .rst(rst),
        .soft_rst(soft_rst),
        .set_vec(wake_a_set),
        .clr(clr_wake_a),
        .flags(wake_a_flags)
    );

    // Wake source register b flags
    wss_flag_bank #(
        .W(2)
    ) u_wake_b (
        .clk_sys(clk_sys),
        .rst(rst),
        .soft_rst(soft_rst),
        .set_vec(wake_b_set),
        .clr(clr_wake_b),
        .flags(wake_b_flags)
    );

    // Switch overload flags; overcurrent and overtemperature share one bit
    wss_flag_bank #(
        .W(4)
    ) u_overload (
        .clk_sys(clk_sys),
        .rst(rst),
        .soft_rst(soft_rst),
        .set_vec(switch_overload_evt), // R14
        .clr(clr_overload),
        .flags(overload_flags)
    );

    // Switch open-load flags
    wss_flag_bank #(
        .W(4)
    ) u_open_load (
        .clk_sys(clk_sys),
        .rst(rst),
        .soft_rst(soft_rst),
        .set_vec(switch_open_load_evt), // R15
        .clr(clr_open_load),
        .flags(open_load_flags)
    );

    // Wake input and general pin level capture
    wss_level_capture u_level (
        .clk_sys(clk_sys),
        .rst(rst),
        .wake_in_pin(wake_in_pin),
        .wake_cyclic(wake_cyclic),
        .sample_strobe(sample_strobe),
        .gen_pin(gen_pin),
        .sbc_mode(sbc_mode),
        .gen_cfg1(gen_cfg1),
        .gen_cfg2(gen_cfg2),
        .gen_sel_gpio(gen_sel_gpio),
        .wake_lvl(wake_lvl),
        .gen_lvl(gen_lvl)
    );

    // Register images; every reserved position is built as zero
    always_comb begin
        img_wake_a = WSS_RST_STATUS; // R6
        img_wake_a[WSS_POS_BUS_WAKE] = wake_a_flags[4]; // R2
        img_wake_a[WSS_POS_TIMER_WAKE] = wake_a_flags[3]; // R2
        img_wake_a[WSS_POS_WAKE_IN_LO +: 3] = wake_a_flags[2:0]; // R2
        img_wake_b = WSS_RST_STATUS; // R6
        img_wake_b[WSS_POS_GEN_WAKE_LO +: 2] = wake_b_flags; // R2
        img_level = WSS_RST_STATUS; // R6
        img_level[WSS_POS_DEV_STRAP] = st_r.dev_mode_strap; // R7
        img_level[WSS_POS_PULLUP_STRAP] = st_r.int_pullup_strap; // R8
        img_level[WSS_POS_GEN_LVL_LO +: 2] = gen_lvl; // R9
        img_level[WSS_POS_WAKE_LVL_LO +: 3] = wake_lvl; // R9
        img_overload = WSS_RST_STATUS; // R17
        img_overload[WSS_POS_SWITCH_LO +: 4] = overload_flags; // R14
        img_open_load = WSS_RST_STATUS; // R17
        img_open_load[WSS_POS_SWITCH_LO +: 4] = open_load_flags; // R15
    end

    // Read multiplexer; unmapped addresses answer zero
    always_comb begin
        unique case (reg_addr)
            WSS_ADDR_WAKE_A: rd_mux = img_wake_a;
            WSS_ADDR_WAKE_B: rd_mux = img_wake_b;
            WSS_ADDR_LEVEL: rd_mux = img_level;
            WSS_ADDR_OVERLOAD: rd_mux = img_overload;
            WSS_ADDR_OPEN_LOAD: rd_mux = img_open_load;
            default: rd_mux = WSS_RD_UNMAPPED;
        endcase
    end

    // Next state: read capture, comparator enable, strap capture
    always_comb begin
        st_nxt = st_r;
        // Read data is latched on a read strobe and held otherwise
        if (rd_en) begin
            st_nxt.rd_data = rd_mux;
        end
        // Comparator runs only in normal or receive-only transceiver mode
        st_nxt.bus_uv_en = bus_xcvr_mode; // R1
        // Straps are taken on the first cycle after reset or restart
        st_nxt.strap_take = restart;
        if (st_r.strap_take) begin
            st_nxt.dev_mode_strap = fail_out3_test_pin; // R7
            st_nxt.int_pullup_strap = int_pullup_sense; // R8
        end
    end

    // State register; strap capture is armed by reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r.rd_data <= WSS_RST_STATUS;
            st_r.bus_uv_en <= 1'b0;
            st_r.dev_mode_strap <= 1'b0;
            st_r.int_pullup_strap <= 1'b0;
            st_r.strap_take <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign rd_data = st_r.rd_data;
    assign bus_supply_undervolt_en = st_r.bus_uv_en;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_uv_enable: assert property (bus_xcvr_mode |=> bus_supply_undervolt_en) // R1
        else $error("comparator not enabled in active transceiver mode");
    chk_uv_disable: assert property (!bus_xcvr_mode |=> !bus_supply_undervolt_en) // R1
        else $error("comparator enabled with transceiver off");
    chk_wake_a_resv: assert property (rd_en && reg_addr == WSS_ADDR_WAKE_A |=> rd_data[7:6] == 2'h0 && !rd_data[3]) // R6
        else $error("reserved wake bits read nonzero");
    chk_switch_resv: assert property (rd_en && reg_addr == WSS_ADDR_OVERLOAD |=> rd_data[7:4] == 4'h0) // R17
        else $error("switch upper nibble read nonzero");
    chk_unmapped_zero: assert property (rd_en && reg_addr == 7'h00 |=> rd_data == WSS_RD_UNMAPPED) // R6
        else $error("unmapped read not zero");
    chk_bus_wake_read: assert property (bus_wake_evt && !soft_rst ##1 rd_en && reg_addr == WSS_ADDR_WAKE_A
        |=> rd_data[WSS_POS_BUS_WAKE]) // R2
        else $error("bus wake flag missing on read");
    chk_overload_read: assert property (switch_overload_evt[3] && !soft_rst ##1 rd_en && reg_addr == WSS_ADDR_OVERLOAD
        |=> rd_data[3]) // R14
        else $error("switch four overload not at bit 3");
    chk_restart_keep: assert property (restart && !soft_rst && !clr_en |=> wake_a_flags == $past(wake_a_flags)
        || $past(|wake_a_set)) // R5
        else $error("restart disturbed wake flags");
    chk_strap_take: assert property (st_r.strap_take |=> img_level[WSS_POS_DEV_STRAP] == $past(fail_out3_test_pin)) // R7
        else $error("development strap not captured");

    cov_failsafe_wake: cover property (failsafe_wake && |wake_a_set);
    cov_clear_read: cover property (rd_en && clr_en && reg_addr == WSS_ADDR_WAKE_A);
    cov_open_load: cover property (|switch_open_load_evt);

endmodule

// File: verif/wss_host_model.sv
// Host controller on the serial control interface, issuing reads and clears
module wss_host_model
    import wss_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Register access
    output logic rd_en,
    output logic clr_en,
    output logic [6:0] reg_addr,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus after power-up
    initial begin
        rd_en = 1'b0;
        clr_en = 1'b0;
        reg_addr = 7'h00;
    end

    // One access at a falling edge: read, clear, or read and clear together
    task automatic access(input logic [6:0] addr, input logic do_rd, input logic do_clr, output logic [7:0] data);
        @(negedge clk_sys);
        rd_en = do_rd;
        clr_en = do_clr;
        reg_addr = addr;
        @(negedge clk_sys);
        rd_en = 1'b0;
        clr_en = 1'b0;
        // Released address shows the inverted address, not the last one
        reg_addr = ~addr;
        // Overload flags near the low supply limit are only advisory to the host
        data = rd_data;
    endtask
endmodule

// File: verif/wss_status_regs_tb_top.sv
// Self-checking bench for the wake and switch status registers
module wss_status_regs_tb_top
    import wss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, resets and access
    logic clk_sys, rst, soft_rst, restart, rd_en, clr_en;
    logic [6:0] reg_addr;
    logic [7:0] rd_data;
    // Transceiver and wake events
    logic bus_xcvr_mode, bus_supply_undervolt_en, bus_wake_evt, timer_wake_evt, failsafe_wake;
    logic [2:0] wake_in_evt, wake_in_pin, wake_cyclic;
    logic [1:0] gen_pin_wake_evt, gen_pin, gen_sel_gpio;
    logic sample_strobe, fail_out3_test_pin, int_pullup_sense;
    wss_mode_t sbc_mode;
    wss_gcfg_t gen_cfg1, gen_cfg2;
    // Switch diagnostics
    logic [3:0] switch_overload_evt, switch_open_load_evt;
    // Bench bookkeeping
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] d;

    // Device under test
    wss_status_regs uut (.clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst), .restart(restart),
        .rd_en(rd_en), .clr_en(clr_en), .reg_addr(reg_addr), .rd_data(rd_data),
        .bus_xcvr_mode(bus_xcvr_mode), .bus_supply_undervolt_en(bus_supply_undervolt_en),
        .bus_wake_evt(bus_wake_evt), .timer_wake_evt(timer_wake_evt), .wake_in_evt(wake_in_evt),
        .gen_pin_wake_evt(gen_pin_wake_evt), .failsafe_wake(failsafe_wake), .wake_in_pin(wake_in_pin),
        .wake_cyclic(wake_cyclic), .sample_strobe(sample_strobe), .gen_pin(gen_pin), .sbc_mode(sbc_mode),
        .gen_cfg1(gen_cfg1), .gen_cfg2(gen_cfg2), .gen_sel_gpio(gen_sel_gpio),
        .fail_out3_test_pin(fail_out3_test_pin), .int_pullup_sense(int_pullup_sense),
        .switch_overload_evt(switch_overload_evt), .switch_open_load_evt(switch_open_load_evt));

    // Host model on the access port
    wss_host_model u_host (.clk_sys(clk_sys), .rd_en(rd_en), .clr_en(clr_en), .reg_addr(reg_addr),
        .rd_data(rd_data));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end

    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Wait for falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Byte compare
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Single-bit compare
    task automatic chk1(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // Read a register and compare
    task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        u_host.access(addr, 1'b1, 1'b0, v);
        chk8(v, exp, $sformatf("reg %h", addr));
    endtask

    // End-of-test line
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    // Main sequence
    initial begin
        // Quiet inputs at time zero
        {rst, soft_rst, restart, bus_xcvr_mode, bus_wake_evt, timer_wake_evt, failsafe_wake} = 7'h40;
        {wake_in_evt, wake_in_pin, wake_cyclic, gen_pin_wake_evt, gen_pin, gen_sel_gpio} = 15'h0000;
        {sample_strobe, fail_out3_test_pin, int_pullup_sense} = 3'h0;
        {switch_overload_evt, switch_open_load_evt} = 8'h00;
        sbc_mode = WSS_MODE_SLEEP;
        gen_cfg1 = WSS_GCFG_OFF;
        gen_cfg2 = WSS_GCFG_OFF;
        tick(12);
        rst = 1'b0;
        // Reset values, unmapped address reads zero
        rd_chk(WSS_ADDR_WAKE_A, 8'h00);
        rd_chk(WSS_ADDR_WAKE_B, 8'h00);
        rd_chk(WSS_ADDR_OVERLOAD, 8'h00);
        rd_chk(WSS_ADDR_OPEN_LOAD, 8'h00);
        rd_chk(7'h49, 8'h00);
        done("reset");
        // Undervolt comparator enable follows mode bit
        bus_xcvr_mode = 1'b1;
        tick(2);
        chk1(bus_supply_undervolt_en, 1'b1, "uv enable");
        bus_xcvr_mode = 1'b0;
        tick(2);
        chk1(bus_supply_undervolt_en, 1'b0, "uv disable");
        done("undervolt");
        // Wake flags, sticky until clear, read and clear together
        tick(1);
        // Events stand from the cycle before the read so the read-back assertion is reached
        bus_wake_evt = 1'b1;
        wake_in_evt = 3'b101;
        rd_chk(WSS_ADDR_WAKE_A, 8'h25);
        bus_wake_evt = 1'b0;
        wake_in_evt = 3'b000;
        rd_chk(WSS_ADDR_WAKE_A, 8'h25);
        u_host.access(WSS_ADDR_WAKE_A, 1'b1, 1'b1, d);
        chk8(d, 8'h25, "read with clear");
        rd_chk(WSS_ADDR_WAKE_A, 8'h00);
        // Wake out of fail-safe sets the same flags
        failsafe_wake = 1'b1;
        timer_wake_evt = 1'b1;
        wake_in_evt = 3'b010;
        tick(1);
        {failsafe_wake, timer_wake_evt, wake_in_evt} = 5'h00;
        rd_chk(WSS_ADDR_WAKE_A, 8'h12);
        // General pin wake flags accumulate
        gen_pin_wake_evt = 2'b01;
        tick(1);
        gen_pin_wake_evt = 2'b10;
        tick(1);
        gen_pin_wake_evt = 2'b00;
        rd_chk(WSS_ADDR_WAKE_B, 8'h30);
        rd_chk(WSS_ADDR_WAKE_A, 8'h12);
        done("wake");
        // Switch flags in separate registers, clear touches one only
        switch_overload_evt = 4'b1001;
        switch_open_load_evt = 4'b0110;
        rd_chk(WSS_ADDR_OVERLOAD, 8'h09);
        {switch_overload_evt, switch_open_load_evt} = 8'h00;
        rd_chk(WSS_ADDR_OPEN_LOAD, 8'h06);
        u_host.access(WSS_ADDR_OVERLOAD, 1'b0, 1'b1, d);
        rd_chk(WSS_ADDR_OVERLOAD, 8'h00);
        rd_chk(WSS_ADDR_OPEN_LOAD, 8'h06);
        switch_overload_evt = 4'b0100;
        tick(1);
        switch_overload_evt = 4'b0000;
        done("switch");
        // Straps are sampled, not live; restart keeps flags and resamples straps
        fail_out3_test_pin = 1'b1;
        int_pullup_sense = 1'b1;
        rd_chk(WSS_ADDR_LEVEL, 8'h00);
        restart = 1'b1;
        tick(1);
        restart = 1'b0;
        rd_chk(WSS_ADDR_WAKE_A, 8'h12);
        rd_chk(WSS_ADDR_WAKE_B, 8'h30);
        rd_chk(WSS_ADDR_OVERLOAD, 8'h04);
        rd_chk(WSS_ADDR_OPEN_LOAD, 8'h06);
        rd_chk(WSS_ADDR_LEVEL, 8'hc0);
        done("restart");
        // Wake input levels, direct then sampled
        wake_in_pin = 3'b101;
        tick(2);
        rd_chk(WSS_ADDR_LEVEL, 8'hc5);
        wake_cyclic = 3'b111;
        wake_in_pin = 3'b010;
        tick(2);
        rd_chk(WSS_ADDR_LEVEL, 8'hc5);
        sample_strobe = 1'b1;
        tick(1);
        sample_strobe = 1'b0;
        rd_chk(WSS_ADDR_LEVEL, 8'hc2);
        // General pin levels by selection, mode and configuration
        gen_pin = 2'b11;
        tick(2);
        rd_chk(WSS_ADDR_LEVEL, 8'hc2);
        gen_sel_gpio = 2'b01;
        gen_cfg1 = WSS_GCFG_LOW_SIDE;
        tick(2);
        rd_chk(WSS_ADDR_LEVEL, 8'hd2);
        sbc_mode = WSS_MODE_NORMAL;
        gen_cfg2 = WSS_GCFG_WAKE;
        tick(2);
        rd_chk(WSS_ADDR_LEVEL, 8'hf2);
        sbc_mode = WSS_MODE_STOP;
        gen_cfg2 = WSS_GCFG_HIGH_SIDE;
        gen_pin = 2'b01;
        tick(2);
        rd_chk(WSS_ADDR_LEVEL, 8'hd2);
        sbc_mode = WSS_MODE_SLEEP;
        gen_pin = 2'b10;
        tick(2);
        rd_chk(WSS_ADDR_LEVEL, 8'hc2);
        sbc_mode = WSS_MODE_OTHER;
        gen_cfg2 = WSS_GCFG_LOW_SIDE;
        gen_pin = 2'b11;
        tick(2);
        rd_chk(WSS_ADDR_LEVEL, 8'hd2);
        done("levels");
        // Soft reset zeroes flags but leaves levels
        soft_rst = 1'b1;
        tick(1);
        soft_rst = 1'b0;
        rd_chk(WSS_ADDR_WAKE_A, 8'h00);
        rd_chk(WSS_ADDR_WAKE_B, 8'h00);
        rd_chk(WSS_ADDR_OVERLOAD, 8'h00);
        rd_chk(WSS_ADDR_OPEN_LOAD, 8'h00);
        rd_chk(WSS_ADDR_LEVEL, 8'hd2);
        done("soft reset");
        conclude();
    end
endmodule
